// [include/scc_pkg.sv]
// shared constants and types of the changeover controller
package scc_pkg;
	localparam int NCH = 11;
	localparam int CHK_W = 8;
	localparam int LVL_W = 4;
	localparam int ATTEN_FIRST = 6;
	localparam int SYNC_W = 2 * NCH + NCH * CHK_W + 4 + 1 + 7;
	localparam int CNT_W = 36;

	localparam longint CLK_NS = 10;
	localparam longint NS_PER_S = 1000000000;
	localparam longint NS_PER_MS = 1000000;
	localparam longint LOCKOUT_S = 60;
	localparam longint STEP_S = 30;
	localparam longint BLINK_MS = 500;
	localparam logic [CNT_W-1:0] LOCKOUT_CYC = CNT_W'(LOCKOUT_S * NS_PER_S / CLK_NS);
	localparam logic [CNT_W-1:0] STEP_CYC = CNT_W'(STEP_S * NS_PER_S / CLK_NS);
	localparam logic [CNT_W-1:0] BLINK_CYC = CNT_W'(BLINK_MS * NS_PER_MS / CLK_NS);
	localparam logic [CNT_W-1:0] SETTLE_CYC = 36'h2;
	localparam logic [CNT_W-1:0] CNT_ONE = 36'h1;

	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam int CTRL_TOG_BIT = 0;
	localparam int CTRL_CLR_BIT = 1;
	localparam int STAT_SRC_BIT = 0;
	localparam int STAT_FLTP_BIT = 1;
	localparam int STAT_FLTB_BIT = 2;
	localparam int STAT_AUTO_BIT = 3;
	localparam int STAT_PANEL_BIT = 4;
	localparam int STAT_DELAY_BIT = 5;
	localparam int STAT_NORM_BIT = 6;

	localparam logic RST_SEL_BAK = 1'b0;
	localparam logic RST_FO_EN = 1'b1;
	localparam logic RST_PANEL_EN = 1'b0;
	localparam logic [LVL_W-1:0] LVL_NONE = 4'h0;

	typedef enum logic [2:0] {
		ST_LOAD = 3'b001,
		ST_HOLD = 3'b010,
		ST_RUN = 3'b100
	} scc_state_e;
endpackage

// [rtl/scc_sync.sv]
// two-flop synchroniser for the pin inputs
module scc_sync
	import scc_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic [WIDTH-1:0] async_in, // pin levels
	output logic [WIDTH-1:0] sync_out // synchronised levels
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} scc_sync_s;

	scc_sync_s cur_reg;
	scc_sync_s cur_next;

	always_comb begin
		cur_next.meta = async_in;
		cur_next.stable = cur_reg.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign sync_out = cur_reg.stable;
endmodule

// [rtl/scc_chk_decode.sv]
// decodes one channel's check-type selector
module scc_chk_decode
	import scc_pkg::*;
#(
	parameter bit ATTEN_CH = 1'b0
) (
	input wire logic [CHK_W-1:0] sel, // closed positions, high = closed
	output logic check_en, // channel is checked
	output logic [LVL_W-1:0] level, // position number, 0 = none
	output logic atten // attenuation option
);
	logic [CHK_W-1:0] lvl_bits;

	always_comb begin
		// on attenuating channels position 8 is no level of its own
		lvl_bits = ATTEN_CH ? {1'b0, sel[CHK_W-2:0]} : sel;
		atten = ATTEN_CH ? sel[CHK_W-1] : 1'b0;
		level = LVL_NONE;
		for (int i = CHK_W - 1; i >= 0; i--) begin
			if (lvl_bits[i]) begin
				level = LVL_W'(i + 1);
			end
		end
		check_en = (level != LVL_NONE);
	end
endmodule

// [rtl/scc_top.sv]
// changeover control: source choice, fault latches, panel lockout, APB status
//
// Contract
// - primary selected after power-up
// - exactly one source indication, matching output
// - normal press toggles if other good/both bad
// - failover switches on fault when enabled
// - failover enabled after power-on
// - startup delay ignores panel, blinks disabled
// - separate fault latch per input
// - latch clears by reset after recovery
// - both fault latches cleared at power-on
// - locked panel accepts only panel toggle
// - panel locks after one idle minute
// - panel starts locked, both indications lit
// - one selector position picks check type
// - position 8: high rate or attenuation
// - normal policy never leaves a good input for a bad one
// - no return to primary until reset
// - override allows bad input, no failover
// - delay steps thirty seconds per position
// - factory delay position five
// - remote auto-switch low disables failover
// - panel and remote toggle ANDed
module scc_top
	import scc_pkg::*;
#(
	parameter logic [CNT_W-1:0] LOCKOUT_CYCLES = LOCKOUT_CYC,
	parameter logic [CNT_W-1:0] STEP_CYCLES = STEP_CYC,
	parameter logic [CNT_W-1:0] BLINK_CYCLES = BLINK_CYC
) (
	input wire logic pclk, // system clock, 100 MHz
	input wire logic presetn, // power-on reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic [NCH-1:0] primary_good, // primary detectors, high = good
	input wire logic [NCH-1:0] backup_good, // backup detectors, high = good
	input wire logic [NCH-1:0][CHK_W-1:0] channel_check_type_selectors, // per channel
	input wire logic [3:0] startup_delay_selector, // hex delay switch
	input wire logic fault_policy_select, // high = normal, low = override
	input wire logic btn_source_n, // panel source button, low = pressed
	input wire logic btn_auto_n, // panel failover button
	input wire logic btn_reset_n, // panel fault reset button
	input wire logic btn_panel_n, // panel enable/lock button
	input wire logic remote_auto_n, // remote, low = failover disabled
	input wire logic remote_toggle_n, // remote source toggle
	input wire logic remote_reset_n, // remote fault reset
	output logic src_primary, // primary routed
	output logic src_backup, // backup routed
	output logic fault_primary, // primary fault latch
	output logic fault_backup, // backup fault latch
	output logic fault_alarm, // any fault latched
	output logic failover_on, // switch-on-fault indication
	output logic failover_off, // failover disabled indication
	output logic panel_enabled, // panel enabled indication
	output logic panel_locked, // panel locked indication
	output logic [NCH-1:0] chk_enable, // channel checked
	output logic [NCH-1:0][LVL_W-1:0] chk_level, // check level per channel
	output logic [NCH-1:0] chk_atten // attenuation per channel
);
	typedef struct packed {
		scc_state_e st;
		logic [CNT_W-1:0] cnt;
		logic [3:0] steps;
		logic [CNT_W-1:0] blink_cnt;
		logic blink;
		logic sel_bak;
		logic fo_en;
		logic panel_en;
		logic [CNT_W-1:0] idle_cnt;
		logic flt_p;
		logic flt_b;
		logic prev_tog;
		logic prev_src;
		logic prev_auto;
		logic prev_rst;
		logic prev_panel;
		logic prev_rrst;
		logic o_src_p;
		logic o_src_b;
		logic o_fo_on;
		logic o_fo_off;
		logic o_alarm;
		logic o_pan_en;
		logic o_pan_lk;
		logic [NCH-1:0] o_chk_en;
		logic [NCH-1:0][LVL_W-1:0] o_chk_lvl;
		logic [NCH-1:0] o_chk_att;
		logic [31:0] o_prdata;
		logic o_pready;
		logic o_pslverr;
	} scc_state_s;

	scc_state_s cur_reg;
	scc_state_s cur_next;

	logic [SYNC_W-1:0] sync_w;
	logic [NCH-1:0] pgood_w;
	logic [NCH-1:0] bgood_w;
	logic [NCH-1:0][CHK_W-1:0] sel_w;
	logic [3:0] dly_w;
	logic normal_w;
	logic src_n_w;
	logic auto_n_w;
	logic rst_n_w;
	logic panel_n_w;
	logic rauto_n_w;
	logic rtog_n_w;
	logic rrst_n_w;
	logic [NCH-1:0] en_w;
	logic [NCH-1:0][LVL_W-1:0] lvl_w;
	logic [NCH-1:0] att_w;
	logic run_w;
	logic pri_bad;
	logic bak_bad;
	logic panel_ok;
	logic tog_n;
	logic tog_req;
	logic auto_press;
	logic rst_req;
	logic panel_press;
	logic activity;
	logic auto_eff;
	logic p_use;
	logic b_use;
	logic cur_use;
	logic oth_use;
	logic do_toggle;
	logic sw_tog;
	logic sw_clr;

	function automatic logic fell(input logic prev, input logic now);
		return prev & ~now;
	endfunction

	scc_sync #(.WIDTH(SYNC_W)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({primary_good, backup_good, channel_check_type_selectors,
			startup_delay_selector, fault_policy_select, btn_source_n, btn_auto_n,
			btn_reset_n, btn_panel_n, remote_auto_n, remote_toggle_n, remote_reset_n}),
		.sync_out(sync_w)
	);

	assign {pgood_w, bgood_w, sel_w, dly_w, normal_w, src_n_w, auto_n_w, rst_n_w,
		panel_n_w, rauto_n_w, rtog_n_w, rrst_n_w} = sync_w;

	for (genvar i = 0; i < NCH; i++) begin : g_dec
		scc_chk_decode #(.ATTEN_CH(i >= ATTEN_FIRST)) u_dec (
			.sel(sel_w[i]),
			.check_en(en_w[i]),
			.level(lvl_w[i]),
			.atten(att_w[i])
		);
	end

	always_comb begin
		cur_next = cur_reg;
		run_w = (cur_reg.st == ST_RUN);
		// detection is held off during the startup delay
		pri_bad = run_w & |(en_w & ~pgood_w);
		bak_bad = run_w & |(en_w & ~bgood_w);
		panel_ok = run_w & cur_reg.panel_en;
		sw_tog = psel & penable & pwrite & (paddr == CTRL_OFS) & pwdata[CTRL_TOG_BIT];
		sw_clr = psel & penable & pwrite & (paddr == CTRL_OFS) & pwdata[CTRL_CLR_BIT];
		tog_n = (src_n_w | ~panel_ok) & rtog_n_w;
		tog_req = run_w & (fell(cur_reg.prev_tog, tog_n) | sw_tog);
		auto_press = panel_ok & fell(cur_reg.prev_auto, auto_n_w);
		rst_req = run_w & ((panel_ok & fell(cur_reg.prev_rst, rst_n_w))
			| fell(cur_reg.prev_rrst, rrst_n_w) | sw_clr);
		panel_press = run_w & fell(cur_reg.prev_panel, panel_n_w);
		activity = panel_press | auto_press
			| (panel_ok & (fell(cur_reg.prev_src, src_n_w) | fell(cur_reg.prev_rst, rst_n_w)));
		cur_next.prev_tog = tog_n;
		cur_next.prev_src = src_n_w;
		cur_next.prev_auto = auto_n_w;
		cur_next.prev_rst = rst_n_w;
		cur_next.prev_panel = panel_n_w;
		cur_next.prev_rrst = rrst_n_w;

		// startup sequencing
		unique case (cur_reg.st)
			ST_LOAD: begin
				cur_next.cnt = cur_reg.cnt + CNT_ONE;
				if (cur_reg.cnt == SETTLE_CYC) begin
					cur_next.cnt = '0;
					cur_next.steps = dly_w;
					cur_next.st = (dly_w == 4'h0) ? ST_RUN : ST_HOLD;
				end
			end
			ST_HOLD: begin
				cur_next.cnt = cur_reg.cnt + CNT_ONE;
				if (cur_reg.cnt == STEP_CYCLES - CNT_ONE) begin
					cur_next.cnt = '0;
					cur_next.steps = cur_reg.steps - 4'h1;
					if (cur_reg.steps == 4'h1) begin
						cur_next.st = ST_RUN;
					end
				end
			end
			ST_RUN: begin
				cur_next.cnt = '0;
			end
		endcase
		cur_next.blink_cnt = cur_reg.blink_cnt + CNT_ONE;
		if (cur_reg.blink_cnt == BLINK_CYCLES - CNT_ONE) begin
			cur_next.blink_cnt = '0;
			cur_next.blink = ~cur_reg.blink;
		end

		// fault latches, a new fault beats a simultaneous reset
		cur_next.flt_p = pri_bad | (cur_reg.flt_p & ~rst_req);
		cur_next.flt_b = bak_bad | (cur_reg.flt_b & ~rst_req);
		cur_next.o_alarm = cur_next.flt_p | cur_next.flt_b;

		// an input counts as good only once its latch is reset too
		p_use = ~pri_bad & ~cur_reg.flt_p;
		b_use = ~bak_bad & ~cur_reg.flt_b;
		cur_use = cur_reg.sel_bak ? b_use : p_use;
		oth_use = cur_reg.sel_bak ? p_use : b_use;
		auto_eff = cur_reg.fo_en & rauto_n_w & normal_w;
		if (normal_w) begin
			do_toggle = (tog_req & (oth_use | ~cur_use))
				| (auto_eff & ~cur_use & oth_use);
		end else begin
			do_toggle = tog_req;
		end
		cur_next.sel_bak = cur_reg.sel_bak ^ do_toggle;

		if (auto_press) begin
			cur_next.fo_en = ~cur_reg.fo_en;
		end

		// panel lock and idle timeout
		if (activity | ~cur_reg.panel_en) begin
			cur_next.idle_cnt = '0;
		end else begin
			cur_next.idle_cnt = cur_reg.idle_cnt + CNT_ONE;
		end
		if (panel_press) begin
			cur_next.panel_en = ~cur_reg.panel_en;
		end else if (cur_reg.panel_en & (cur_reg.idle_cnt == LOCKOUT_CYCLES - CNT_ONE)) begin
			cur_next.panel_en = 1'b0;
		end

		// indicators
		cur_next.o_src_p = ~cur_next.sel_bak;
		cur_next.o_src_b = cur_next.sel_bak;
		cur_next.o_fo_on = run_w & auto_eff;
		cur_next.o_fo_off = run_w ? ~auto_eff : cur_reg.blink;
		cur_next.o_pan_en = ~run_w | cur_reg.panel_en;
		cur_next.o_pan_lk = ~run_w | ~cur_reg.panel_en;
		cur_next.o_chk_en = en_w;
		cur_next.o_chk_lvl = lvl_w;
		cur_next.o_chk_att = att_w;

		// apb: data and error prepared in the setup cycle, ready always high
		cur_next.o_pready = 1'b1;
		if (psel & ~penable) begin
			cur_next.o_prdata = '0;
			cur_next.o_pslverr = 1'b0;
			if (paddr == STAT_OFS) begin
				cur_next.o_prdata[STAT_SRC_BIT] = cur_reg.sel_bak;
				cur_next.o_prdata[STAT_FLTP_BIT] = cur_reg.flt_p;
				cur_next.o_prdata[STAT_FLTB_BIT] = cur_reg.flt_b;
				cur_next.o_prdata[STAT_AUTO_BIT] = auto_eff;
				cur_next.o_prdata[STAT_PANEL_BIT] = cur_reg.panel_en;
				cur_next.o_prdata[STAT_DELAY_BIT] = ~run_w;
				cur_next.o_prdata[STAT_NORM_BIT] = normal_w;
			end else if (paddr != CTRL_OFS) begin
				cur_next.o_pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_reg <= '0;
			cur_reg.st <= ST_LOAD;
			cur_reg.sel_bak <= RST_SEL_BAK;
			cur_reg.fo_en <= RST_FO_EN;
			cur_reg.panel_en <= RST_PANEL_EN;
			cur_reg.flt_p <= 1'b0;
			cur_reg.flt_b <= 1'b0;
			cur_reg.o_src_p <= 1'b1;
			cur_reg.o_pan_en <= 1'b1;
			cur_reg.o_pan_lk <= 1'b1;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign prdata = cur_reg.o_prdata;
	assign pready = cur_reg.o_pready;
	assign pslverr = cur_reg.o_pslverr;
	assign src_primary = cur_reg.o_src_p;
	assign src_backup = cur_reg.o_src_b;
	assign fault_primary = cur_reg.flt_p;
	assign fault_backup = cur_reg.flt_b;
	assign fault_alarm = cur_reg.o_alarm;
	assign failover_on = cur_reg.o_fo_on;
	assign failover_off = cur_reg.o_fo_off;
	assign panel_enabled = cur_reg.o_pan_en;
	assign panel_locked = cur_reg.o_pan_lk;
	assign chk_enable = cur_reg.o_chk_en;
	assign chk_level = cur_reg.o_chk_lvl;
	assign chk_atten = cur_reg.o_chk_att;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_source_onehot: assert property (
		src_primary != src_backup && src_backup == cur_reg.sel_bak)
		else $error("source indications not one-hot or wrong");
	chk_powerup_primary: assert property (
		cur_reg.st == ST_LOAD |-> !cur_reg.sel_bak && src_primary)
		else $error("primary not selected at power-up");
	chk_failover_default: assert property (cur_reg.st == ST_LOAD |-> cur_reg.fo_en)
		else $error("failover not enabled at power-up");
	chk_delay_ignores: assert property (
		!run_w |=> $stable(cur_reg.sel_bak) && $stable(cur_reg.fo_en))
		else $error("control acted on during startup delay");
	chk_failover_single: assert property (run_w |=> failover_on != failover_off)
		else $error("failover indications not exclusive");
	chk_fault_sets: assert property (pri_bad |=> fault_primary && fault_alarm)
		else $error("primary fault not latched");
	chk_fault_holds: assert property (cur_reg.flt_b && !rst_req |=> fault_backup)
		else $error("backup fault dropped without reset");
	chk_lock_ignores: assert property (
		run_w && !cur_reg.panel_en && !panel_press
		|=> $stable(cur_reg.fo_en) && !cur_reg.panel_en)
		else $error("locked panel accepted a control");
	chk_idle_lockout: assert property (
		cur_reg.panel_en && !panel_press && cur_reg.idle_cnt == LOCKOUT_CYCLES - CNT_ONE
		|=> !cur_reg.panel_en)
		else $error("panel did not lock after idle time");
	chk_startup_panel: assert property (!run_w |=> panel_enabled && panel_locked)
		else $error("panel indications wrong during startup");
	chk_normal_keeps: assert property (
		normal_w && run_w && cur_use && !oth_use |=> $stable(cur_reg.sel_bak))
		else $error("switched to a bad input in normal policy");
	chk_override_noauto: assert property (
		!normal_w && !tog_req |=> $stable(cur_reg.sel_bak))
		else $error("override policy switched without a press");
	chk_remote_auto: assert property (run_w && !rauto_n_w |=> !failover_on)
		else $error("remote disable did not stop failover");

	cov_auto_switch: cover property (auto_eff && !tog_req && do_toggle);
	cov_manual_toggle: cover property (tog_req && do_toggle);
	cov_idle_lock: cover property (cur_reg.panel_en ##1 !cur_reg.panel_en && !$past(panel_press));
	cov_fault_clear: cover property (cur_reg.flt_p && rst_req && !pri_bad);
endmodule

// [testbench/scc_partner.sv]
// behavioural detectors and operator buttons facing the changeover control
module scc_partner
	import scc_pkg::*;
(
	input wire logic pclk, // system clock
	output logic [NCH-1:0] primary_good, // primary detectors, high = good
	output logic [NCH-1:0] backup_good, // backup detectors, high = good
	output logic [5:0] strobe_n, // src, auto, reset, panel, remote toggle, remote reset
	output logic remote_auto_n // remote failover inhibit, low = inhibit
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		primary_good = '1;
		backup_good = '1;
		strobe_n = '1;
		remote_auto_n = 1'b1;
	end

	// four edges low then four high, above the two the synchroniser needs
	task automatic press(input int k);
		@(posedge pclk);
		strobe_n[k] <= 1'b0;
		repeat (4) @(posedge pclk);
		strobe_n[k] <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask

	task automatic set_good(input int ch, input logic p, input logic b);
		@(posedge pclk);
		primary_good[ch] <= p;
		backup_good[ch] <= b;
	endtask

	task automatic set_auto(input logic v);
		@(posedge pclk);
		remote_auto_n <= v;
	endtask
endmodule

// [testbench/sync_changeover_control_tb.sv]
// self-checking bench for the changeover control block
module sync_changeover_control_tb
	import scc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, fault_policy_select = 1'b1;
	logic [NCH-1:0] primary_good, backup_good, chk_enable, chk_atten;
	logic [NCH-1:0][CHK_W-1:0] sel_q;
	logic [NCH-1:0][LVL_W-1:0] chk_level;
	logic [5:0] strobe_n;
	logic [3:0] dly_sel = 4'h2;
	logic remote_auto_n, src_primary, src_backup, fault_primary, fault_backup, fault_alarm;
	logic failover_on, failover_off, panel_enabled, panel_locked;
	int n_fail = 0, checks_done = 0, cyc = 0;

	always #5 pclk = ~pclk;

	scc_top #(.LOCKOUT_CYCLES(36'hC8), .STEP_CYCLES(36'h32), .BLINK_CYCLES(36'h8)) scc_top_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.primary_good(primary_good), .backup_good(backup_good),
		.channel_check_type_selectors(sel_q), .startup_delay_selector(dly_sel),
		.fault_policy_select(fault_policy_select), .btn_source_n(strobe_n[0]),
		.btn_auto_n(strobe_n[1]), .btn_reset_n(strobe_n[2]), .btn_panel_n(strobe_n[3]),
		.remote_auto_n(remote_auto_n), .remote_toggle_n(strobe_n[4]),
		.remote_reset_n(strobe_n[5]), .src_primary(src_primary), .src_backup(src_backup),
		.fault_primary(fault_primary), .fault_backup(fault_backup), .fault_alarm(fault_alarm),
		.failover_on(failover_on), .failover_off(failover_off),
		.panel_enabled(panel_enabled), .panel_locked(panel_locked),
		.chk_enable(chk_enable), .chk_level(chk_level), .chk_atten(chk_atten));

	scc_partner scc_partner_i (.pclk(pclk), .primary_good(primary_good),
		.backup_good(backup_good), .strobe_n(strobe_n), .remote_auto_n(remote_auto_n));

	task automatic results();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			results();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic pr(input int k);
		scc_partner_i.press(k);
		wt(6);
	endtask

	task automatic sg(input int ch, input logic p, input logic b);
		scc_partner_i.set_good(ch, p, b);
		wt(10);
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic t_startup();
		int hi, lo;
		chk({src_primary, src_backup}, 2'h2);
		chk({fault_primary, fault_backup}, 2'h0);
		chk({panel_enabled, panel_locked}, 2'h3);
		pr(0);
		pr(3);
		chk({src_primary, panel_enabled, panel_locked}, 3'h7);
		hi = 0;
		lo = 0;
		repeat (24) begin
			@(posedge pclk);
			if (failover_off === 1'b1)
				hi++;
			if (failover_off === 1'b0)
				lo++;
		end
		chk({failover_on, hi > 0, lo > 0}, 3'h3);
	endtask

	task automatic t_delay();
		logic [31:0] d;
		logic e;
		while (cyc < 98) @(posedge pclk);
		chk(failover_on, 1'b0);
		while (cyc < 120) @(posedge pclk);
		chk({failover_on, failover_off, panel_enabled, panel_locked}, 4'h9);
		chk(chk_enable[0], 1'b0);
		chk(chk_level[2], 4'h3);
		chk({chk_level[1], chk_atten[1]}, 5'h10);
		chk({chk_level[7], chk_atten[7]}, 5'h0D);
		chk({chk_level[8], chk_atten[8]}, 5'h0F);
		apb(1'b0, STAT_OFS, 32'h0, d, e);
		chk(d, 32'h48);
		apb(1'b0, 8'h08, 32'h0, d, e);
		chk({e, d[30:0]}, 32'h80000000);
		apb(1'b1, CTRL_OFS, 32'h1, d, e);
		wt(4);
		chk({src_primary, src_backup}, 2'h1);
		apb(1'b0, CTRL_OFS, 32'h0, d, e);
		chk(d, 32'h0);
		apb(1'b1, CTRL_OFS, 32'h1, d, e);
		wt(4);
		chk(src_primary, 1'b1);
	endtask

	task automatic t_panel();
		pr(0);
		chk(src_primary, 1'b1);
		pr(3);
		chk({panel_enabled, panel_locked}, 2'h2);
		pr(0);
		chk({src_primary, src_backup}, 2'h1);
		pr(1);
		chk({failover_on, failover_off}, 2'h1);
		pr(1);
		chk({failover_on, failover_off}, 2'h2);
		wt(140);
		pr(0);
		wt(140);
		chk({panel_enabled, panel_locked, src_primary}, 3'h5);
		wt(70);
		chk({panel_enabled, panel_locked}, 2'h1);
	endtask

	task automatic t_fault();
		sg(0, 1'b0, 1'b0);
		chk({fault_primary, fault_backup}, 2'h0);
		sg(3, 1'b0, 1'b1);
		chk({src_primary, src_backup, fault_primary, fault_alarm}, 4'h7);
		sg(3, 1'b1, 1'b1);
		chk(fault_primary, 1'b1);
		pr(4);
		chk(src_backup, 1'b1);
		pr(2);
		chk(fault_primary, 1'b1);
		pr(5);
		chk(fault_primary, 1'b0);
		pr(4);
		chk(src_primary, 1'b1);
		sg(3, 1'b0, 1'b0);
		chk({src_primary, fault_primary, fault_backup}, 3'h7);
		pr(4);
		chk(src_backup, 1'b1);
		sg(3, 1'b1, 1'b1);
		pr(5);
		pr(4);
		chk({src_primary, fault_primary, fault_backup}, 3'h4);
	endtask

	task automatic t_policy();
		scc_partner_i.set_auto(1'b0);
		sg(3, 1'b0, 1'b1);
		chk({src_primary, fault_primary}, 2'h3);
		sg(3, 1'b1, 1'b1);
		pr(5);
		scc_partner_i.set_auto(1'b1);
		fault_policy_select <= 1'b0;
		sg(3, 1'b1, 1'b0);
		pr(4);
		wt(10);
		chk({src_backup, fault_backup}, 2'h3);
		sg(3, 1'b1, 1'b1);
		pr(5);
		fault_policy_select <= 1'b1;
		pr(4);
		chk({src_primary, fault_backup}, 2'h2);
	endtask

	// software clear, then a mid-run reset with no delay and channel 3 unchecked
	task automatic t_restart();
		logic [31:0] d;
		logic e;
		sg(4, 1'b0, 1'b1);
		chk({src_backup, fault_primary}, 2'h3);
		sg(4, 1'b1, 1'b1);
		apb(1'b1, CTRL_OFS, 32'h2, d, e);
		wt(2);
		chk(fault_primary, 1'b0);
		sg(3, 1'b0, 1'b1);
		chk({src_backup, fault_primary}, 2'h3);
		presetn <= 1'b0;
		dly_sel <= 4'h0;
		sel_q[3] <= 8'h00;
		repeat (3) @(posedge pclk);
		chk({src_primary, fault_primary, fault_backup}, 3'h4);
		presetn <= 1'b1;
		wt(8);
		chk({src_primary, fault_primary, failover_on, failover_off}, 4'hA);
	endtask

	initial begin
		sel_q = {NCH{8'h01}};
		sel_q[0] = 8'h00;
		sel_q[1] = 8'h80;
		sel_q[2] = 8'h04;
		sel_q[7] = 8'hA0;
		sel_q[8] = 8'hC0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		wt(2);
		t_startup();
		t_delay();
		t_panel();
		t_fault();
		t_policy();
		t_restart();
		results();
	end
endmodule
